// ===== pkg/flash_ctrl_pkg.sv
//==========================================================================
// Summary of operation
// - Resumed erase continues without rechecking lock changes made while suspended.
// - Program suspend: reads accepted except suspended page, which returns junk.
// - Program suspend accepts volatile and enhanced-volatile config writes.
// - One nesting level: first resume restarts program, second the erase.
// - One state at a time; standby accepts all but suspend and resume.
// - Busy accepts only status reads, flag reads and suspend.
// - Status, nonvolatile config, OTP program, bulk erase only in standby.
// - Enable, disable, flag clear, lock, volatile writes: standby or suspend.
// - Sector and subsector erase accepted only in standby.
// - Sector erase suspend: program other sectors; other suspends reject programs.
// - Reads to erase-suspended sector accepted, data not guaranteed.
// - Resume sets busy, clears controller-ready flag; ignored if nothing suspended.
// - OTP read shifts data out on falling edges, address steps per byte.
// - OTP read address does not wrap; holds at location 40h.
// - OTP program ignored without write enable; no flags set.
// - OTP program needs code, address, whole data bytes; else skipped.
// - At most 65 OTP data bytes latched; later bytes discarded.
// - OTP program sets busy, clears write enable, busy clears at end.
// - OTP program failing at timer end clears write enable and sets program fail flag.
// - Control byte 64 bit 0: 1 allows program, 0 locks forever.
// - Locked OTP program ignored, enable kept, flag bits 1 and 4 set.
//==========================================================================
package flash_ctrl_pkg;
	// Command codes
	localparam logic [7:0] CMD_WREN = 8'h06;
	localparam logic [7:0] CMD_WRDI = 8'h04;
	localparam logic [7:0] CMD_RDSR = 8'h05;
	localparam logic [7:0] CMD_RDFSR = 8'h70;
	localparam logic [7:0] CMD_CLFSR = 8'h50;
	localparam logic [7:0] CMD_WRSR = 8'h01;
	localparam logic [7:0] CMD_WRLR = 8'hE5;
	localparam logic [7:0] CMD_WRNVCR = 8'hB1;
	localparam logic [7:0] CMD_WRVCR = 8'h81;
	localparam logic [7:0] CMD_WREVCR = 8'h61;
	localparam logic [7:0] CMD_READ = 8'h03;
	localparam logic [7:0] CMD_PP = 8'h02;
	localparam logic [7:0] CMD_SE = 8'hD8;
	localparam logic [7:0] CMD_SSE = 8'h20;
	localparam logic [7:0] CMD_BE = 8'hC7;
	localparam logic [7:0] CMD_SUSP = 8'h75;
	localparam logic [7:0] CMD_RESUME = 8'h7A;
	localparam logic [7:0] CMD_OTPRD = 8'h4B;
	localparam logic [7:0] CMD_OTPPG = 8'h42;
	// OTP geometry
	localparam int OTP_BYTES = 65;
	localparam logic [6:0] OTP_LAST = 7'h40;
	localparam int OTP_LOCK_BIT = 0;
	localparam int OTP_DUMMY = 8;
	// Flag status bit positions
	localparam int FS_READY = 7;
	localparam int FS_ERSUSP = 6;
	localparam int FS_ERFAIL = 5;
	localparam int FS_PGFAIL = 4;
	localparam int FS_PGSUSP = 2;
	localparam int FS_PROT = 1;
	localparam logic [7:0] FS_RESET = 8'h80;
	// Self-timed OTP program time
	localparam int T_POTP_US = 100;
	localparam int CLK_MHZ = 20;
	localparam int POTP_CYC = T_POTP_US * CLK_MHZ;
	// Device state
	typedef enum logic [2:0] {
		ST_STANDBY, ST_BUSY, ST_SSE_SUSP, ST_SE_SUSP, ST_PG_SUSP, ST_NEST_SUSP
	} dev_state_t;
	// Command admission classes
	typedef enum logic [3:0] {
		CL_READ, CL_PROG, CL_ERASE, CL_WR_IDLE, CL_WR_ANY, CL_STAT,
		CL_SUSP, CL_RESUME, CL_OTPRD, CL_OTPPG, CL_OTHER
	} cmd_class_t;
endpackage

// ===== design/otp_mem.sv
//==========================================================================
// OTP array storage with registered read data
module otp_mem
	import flash_ctrl_pkg::*;
#(
	parameter int DEPTH = OTP_BYTES
) (
	// Clock
	input wire logic core_clk,
	// Write port
	input wire logic wrEn,
	input wire logic [6:0] wrAddr,
	input wire logic [7:0] wrData,
	// Read port
	input wire logic [6:0] rdAddr,
	output logic [7:0] rdData_r
);
	logic [7:0] mem [DEPTH];

	// Programming clears bits only, as flash does
	always_ff @(posedge core_clk) begin
		if (wrEn) begin
			mem[wrAddr] <= mem[wrAddr] & wrData;
		end
	end

	// Registered read
	always_ff @(posedge core_clk) begin
		rdData_r <= mem[rdAddr];
	end

	// Erased state is all ones
	initial begin
		for (int i = 0; i < DEPTH; i++) begin
			mem[i] = 8'hFF;
		end
	end
endmodule

// ===== design/pin_sync.sv
//==========================================================================
// Two-flop synchroniser for pin inputs
module pin_sync #(
	parameter int W = 3
) (
	// Clock
	input wire logic core_clk,
	// Data
	input wire logic [W-1:0] asyncIn,
	output logic [W-1:0] syncOut
);
	logic [W-1:0] meta_r;

	// First stage read only by second stage
	always_ff @(posedge core_clk) begin
		meta_r <= asyncIn;
		syncOut <= meta_r;
	end
endmodule

// ===== design/flash_suspend_resume_otp_ctrl.sv
//==========================================================================
// Command admission, resume and OTP engine of a serial flash
module flash_suspend_resume_otp_ctrl
	import flash_ctrl_pkg::*;
#(
	parameter int POTP_CYCLES = POTP_CYC
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Serial link pins
	input wire logic selectN,
	input wire logic serialClk,
	input wire logic serial_in_line,
	output logic serial_out_line_r,
	output logic serialOutEn_r,
	// Array side state
	input wire logic arrayOpDone,
	input wire logic arrayOpFail,
	input wire logic [15:0] suspSector,
	input wire logic [23:0] suspPage,
	// Suspend events from the suspend logic
	input wire logic suspEraseSse,
	input wire logic suspEraseSe,
	input wire logic suspProgram,
	input wire logic busyStart,
	// Status
	output logic [2:0] devState_r,
	output logic wel_r,
	output logic wip_r,
	output logic [7:0] flagStat_r,
	output logic otpLocked_r,
	output logic [7:0] cmdCode_r,
	output logic cmdAccepted_r,
	output logic cmdRejected_r,
	output logic dataUndefined_r,
	output logic lockRecheck_r
);
	import flash_ctrl_pkg::*;

	//======================================================================
	// Pin synchronisation and edge finding
	logic [2:0] pinsS;
	logic selN, sclk, sin;
	logic sclkD_r, selND_r;
	logic rise, fall, frameEnd;
	pin_sync #(.W(3)) u_sync (
		.core_clk(core_clk),
		.asyncIn({selectN, serialClk, serial_in_line}),
		.syncOut(pinsS)
	);
	assign selN = pinsS[2];
	assign sclk = pinsS[1];
	assign sin = pinsS[0];

	// Previous samples for edge detection
	always_ff @(posedge core_clk) begin
		if (rst) begin
			sclkD_r <= 1'b0;
			selND_r <= 1'b1;
		end else begin
			sclkD_r <= sclk;
			selND_r <= selN;
		end
	end
	assign rise = sclk & ~sclkD_r & ~selN;
	assign fall = ~sclk & sclkD_r & ~selN;
	assign frameEnd = selN & ~selND_r;

	//======================================================================
	// Command classification
	function automatic cmd_class_t classify(input logic [7:0] c);
		unique case (c)
			CMD_READ: classify = CL_READ;
			CMD_PP: classify = CL_PROG;
			CMD_SE, CMD_SSE: classify = CL_ERASE;
			CMD_WRSR, CMD_WRNVCR, CMD_BE: classify = CL_WR_IDLE;
			CMD_WREN, CMD_WRDI, CMD_CLFSR, CMD_WRLR,
			CMD_WRVCR, CMD_WREVCR: classify = CL_WR_ANY;
			CMD_RDSR, CMD_RDFSR: classify = CL_STAT;
			CMD_SUSP: classify = CL_SUSP;
			CMD_RESUME: classify = CL_RESUME;
			CMD_OTPRD: classify = CL_OTPRD;
			CMD_OTPPG: classify = CL_OTPPG;
			default: classify = CL_OTHER;
		endcase
	endfunction

	//======================================================================
	// Serial shift in: bit counter, command, address, data
	logic [9:0] bitCnt_r;
	logic [7:0] shIn_r;
	logic [23:0] addr_r;
	logic [6:0] otpPtr_r;
	logic [6:0] pgCnt_r;
	logic byteDone;
	logic [7:0] byteNow;
	dev_state_t st_r;
	cmd_class_t cls;
	logic admit;
	assign byteNow = {shIn_r[6:0], sin};
	assign byteDone = rise & (bitCnt_r[2:0] == 3'h7);
	assign cls = classify(cmdCode_r);

	// Bits sampled on rising serial clock
	always_ff @(posedge core_clk) begin
		if (rst) begin
			bitCnt_r <= 10'h000;
			shIn_r <= 8'h00;
			cmdCode_r <= 8'h00;
			addr_r <= 24'h000000;
		end else if (selN) begin
			bitCnt_r <= 10'h000;
		end else if (rise) begin
			shIn_r <= byteNow;
			if (bitCnt_r != 10'h3FF) begin
				bitCnt_r <= bitCnt_r + 10'h001;
			end
			if (bitCnt_r == 10'h007) begin
				cmdCode_r <= byteNow;
			end
			if (bitCnt_r >= 10'h008 && bitCnt_r < 10'h020) begin
				addr_r <= {addr_r[22:0], sin};
			end
		end
	end

	//======================================================================
	// Admission table by device state
	always_comb begin
		admit = 1'b0;
		unique case (st_r)
			ST_STANDBY: admit = (cls != CL_SUSP) && (cls != CL_RESUME);
			ST_BUSY: admit = (cls == CL_STAT) || (cls == CL_SUSP);
			ST_SE_SUSP: admit = (cls == CL_READ) || (cls == CL_WR_ANY) ||
				(cls == CL_STAT) || (cls == CL_RESUME) ||
				(cls == CL_OTPRD) ||
				((cls == CL_PROG) && (addr_r[23:16] != suspSector[7:0]));
			ST_SSE_SUSP, ST_PG_SUSP, ST_NEST_SUSP: admit = (cls == CL_READ) ||
				(cls == CL_WR_ANY) || (cls == CL_STAT) ||
				(cls == CL_RESUME) || (cls == CL_OTPRD);
			default: admit = 1'b0;
		endcase
		// Erase and standby-only writes fall through as refused
	end

	// Accept/reject report at frame end
	always_ff @(posedge core_clk) begin
		if (rst) begin
			cmdAccepted_r <= 1'b0;
			cmdRejected_r <= 1'b0;
		end else begin
			cmdAccepted_r <= frameEnd & (bitCnt_r >= 10'h008) & admit;
			cmdRejected_r <= frameEnd & (bitCnt_r >= 10'h008) & ~admit;
		end
	end

	// Reads of suspended page or sector give undefined data
	always_ff @(posedge core_clk) begin
		if (rst) begin
			dataUndefined_r <= 1'b0;
		end else if (selN) begin
			dataUndefined_r <= 1'b0;
		end else if (cls == CL_READ && bitCnt_r == 10'h020) begin
			dataUndefined_r <= ((st_r == ST_PG_SUSP || st_r == ST_NEST_SUSP)
				&& addr_r[23:8] == suspPage[23:8]) ||
				((st_r == ST_SE_SUSP || st_r == ST_SSE_SUSP)
				&& addr_r[23:16] == suspSector[7:0]);
		end
	end

	//======================================================================
	// OTP program data latch, up to 65 bytes
	logic memWr;
	logic [6:0] memWrAddr;
	logic [7:0] otpRd;
	logic [7:0] pgBuf_r [OTP_BYTES];
	logic [6:0] wrIdx_r;
	logic writing_r;
	logic wholeBytes;
	assign wholeBytes = (bitCnt_r[2:0] == 3'h0) && (bitCnt_r >= 10'h028);

	// Data bytes after the address, extras discarded
	always_ff @(posedge core_clk) begin
		if (rst) begin
			pgCnt_r <= 7'h00;
		end else if (selN) begin
			pgCnt_r <= pgCnt_r;
		end else if (bitCnt_r == 10'h000) begin
			pgCnt_r <= 7'h00;
		end else if (byteDone && cls == CL_OTPPG && bitCnt_r >= 10'h020 &&
				pgCnt_r < 7'(OTP_BYTES)) begin
			pgBuf_r[pgCnt_r] <= byteNow;
			pgCnt_r <= pgCnt_r + 7'h01;
		end
	end

	assign memWr = writing_r & (wrIdx_r < pgCnt_r);
	assign memWrAddr = 7'(addr_r[6:0] + wrIdx_r) > OTP_LAST ? OTP_LAST :
		7'(addr_r[6:0] + wrIdx_r);

	otp_mem #(.DEPTH(OTP_BYTES)) u_mem (
		.core_clk(core_clk),
		.wrEn(memWr),
		.wrAddr(memWrAddr),
		.wrData(pgBuf_r[wrIdx_r]),
		.rdAddr(otpPtr_r),
		.rdData_r(otpRd)
	);

	//======================================================================
	// OTP read: pointer and falling-edge shift out
	logic [7:0] shOut_r;
	logic rdPhase;
	assign rdPhase = (cls == CL_OTPRD) && admit &&
		(bitCnt_r >= 10'(32 + OTP_DUMMY));

	// Pointer advances per byte and saturates at 40h
	always_ff @(posedge core_clk) begin
		if (rst) begin
			otpPtr_r <= 7'h00;
		end else if (rise && bitCnt_r == 10'h01F) begin
			otpPtr_r <= {addr_r[5:0], sin} > OTP_LAST ? OTP_LAST :
				{addr_r[5:0], sin};
		end else if (rdPhase && byteDone && otpPtr_r != OTP_LAST) begin
			otpPtr_r <= otpPtr_r + 7'h01;
		end
	end

	// Output shifter on falling edges until select rises
	always_ff @(posedge core_clk) begin
		if (rst) begin
			shOut_r <= 8'hFF;
			serial_out_line_r <= 1'b0;
			serialOutEn_r <= 1'b0;
		end else if (selN) begin
			serialOutEn_r <= 1'b0;
		end else if (rdPhase && fall) begin
			serialOutEn_r <= 1'b1;
			if (bitCnt_r[2:0] == 3'h0) begin
				serial_out_line_r <= otpRd[7];
				shOut_r <= {otpRd[6:0], 1'b0};
			end else begin
				serial_out_line_r <= shOut_r[7];
				shOut_r <= {shOut_r[6:0], 1'b0};
			end
		end
	end

	//======================================================================
	// Device state, resume and OTP program engine
	logic [15:0] timer_r;
	logic otpRun_r;
	logic goOtp;
	logic nestPend_r;
	assign goOtp = frameEnd && cls == CL_OTPPG && admit && wholeBytes &&
		wel_r && ~otpLocked_r;

	// State transitions
	always_ff @(posedge core_clk) begin
		if (rst) begin
			st_r <= ST_STANDBY;
			lockRecheck_r <= 1'b0;
		end else begin
			lockRecheck_r <= 1'b0;
			if (frameEnd && cls == CL_RESUME && admit) begin
				unique case (st_r)
					ST_NEST_SUSP: st_r <= ST_BUSY;
					default: st_r <= ST_BUSY;
				endcase
			end else if (goOtp || busyStart) begin
				st_r <= ST_BUSY;
			end else if (st_r == ST_BUSY && suspProgram) begin
				st_r <= (nestPend_r) ? ST_NEST_SUSP : ST_PG_SUSP;
			end else if (st_r == ST_BUSY && suspEraseSe) begin
				st_r <= ST_SE_SUSP;
			end else if (st_r == ST_BUSY && suspEraseSse) begin
				st_r <= ST_SSE_SUSP;
			end else if (st_r == ST_BUSY && (arrayOpDone ||
					(otpRun_r && timer_r == 16'h0000))) begin
				st_r <= nestPend_r ? ST_SE_SUSP : ST_STANDBY;
			end
		end
	end

	// Remembers an erase suspended beneath a program
	always_ff @(posedge core_clk) begin
		if (rst) begin
			nestPend_r <= 1'b0;
		end else if (goOtp || busyStart) begin
			nestPend_r <= (st_r == ST_SE_SUSP) || (st_r == ST_SSE_SUSP);
		end else if (frameEnd && cls == CL_RESUME && admit &&
				st_r != ST_NEST_SUSP) begin
			nestPend_r <= 1'b0;
		end
	end

	// Self-timed OTP program counter and writer
	always_ff @(posedge core_clk) begin
		if (rst) begin
			otpRun_r <= 1'b0;
			timer_r <= 16'h0000;
			writing_r <= 1'b0;
			wrIdx_r <= 7'h00;
		end else if (goOtp) begin
			otpRun_r <= 1'b1;
			timer_r <= 16'(POTP_CYCLES - 1);
			writing_r <= 1'b1;
			wrIdx_r <= 7'h00;
		end else if (otpRun_r) begin
			if (writing_r) begin
				wrIdx_r <= wrIdx_r + 7'h01;
				writing_r <= (wrIdx_r + 7'h01) < pgCnt_r;
			end
			if (timer_r == 16'h0000) begin
				otpRun_r <= 1'b0;
			end else begin
				timer_r <= timer_r - 16'h0001;
			end
		end
	end

	// Lock bit reflects control byte 64 bit 0
	always_ff @(posedge core_clk) begin
		if (rst) begin
			otpLocked_r <= 1'b0;
		end else if (memWr && memWrAddr == OTP_LAST &&
				!pgBuf_r[wrIdx_r][OTP_LOCK_BIT]) begin
			otpLocked_r <= 1'b1;
		end
	end

	//======================================================================
	// Write enable latch, busy bit and flag status
	logic otpLockHit;
	assign otpLockHit = frameEnd && cls == CL_OTPPG && admit && wholeBytes &&
		wel_r && otpLocked_r;

	// Write enable latch
	always_ff @(posedge core_clk) begin
		if (rst) begin
			wel_r <= 1'b0;
		end else if (goOtp) begin
			wel_r <= 1'b0;
		end else if (otpRun_r && timer_r == 16'h0000 && arrayOpFail) begin
			wel_r <= 1'b0;
		end else if (frameEnd && admit && bitCnt_r == 10'h008) begin
			if (cmdCode_r == CMD_WREN) wel_r <= 1'b1;
			else if (cmdCode_r == CMD_WRDI) wel_r <= 1'b0;
		end
	end

	// Busy bit
	always_ff @(posedge core_clk) begin
		if (rst) begin
			wip_r <= 1'b0;
		end else if ((frameEnd && cls == CL_RESUME && admit) ||
				goOtp || busyStart) begin
			wip_r <= 1'b1;
		end else if (st_r == ST_BUSY && (arrayOpDone || suspProgram ||
				suspEraseSe || suspEraseSse ||
				(otpRun_r && timer_r == 16'h0000))) begin
			wip_r <= 1'b0;
		end
	end

	// Flag status; hardware sets win over clear
	always_ff @(posedge core_clk) begin
		if (rst) begin
			flagStat_r <= FS_RESET;
		end else begin
			logic [7:0] f;
			f = flagStat_r;
			if (frameEnd && cmdCode_r == CMD_CLFSR && admit &&
					bitCnt_r == 10'h008) f = 8'h00 | (f & 8'hC4);
			if (frameEnd && cls == CL_RESUME && admit) begin
				f[FS_READY] = 1'b0;
				f[FS_PGSUSP] = 1'b0;
				if (st_r != ST_NEST_SUSP) f[FS_ERSUSP] = 1'b0;
			end
			if (goOtp || busyStart) f[FS_READY] = 1'b0;
			if (suspProgram) f[FS_PGSUSP] = 1'b1;
			if (suspEraseSe || suspEraseSse) f[FS_ERSUSP] = 1'b1;
			if (st_r == ST_BUSY && (suspProgram || suspEraseSe ||
					suspEraseSse || arrayOpDone)) f[FS_READY] = 1'b1;
			if (otpRun_r && timer_r == 16'h0000) begin
				f[FS_READY] = 1'b1;
				if (arrayOpFail) f[FS_PGFAIL] = 1'b1;
			end
			if (otpLockHit) begin
				f[FS_PROT] = 1'b1;
				f[FS_PGFAIL] = 1'b1;
			end
			flagStat_r <= f;
		end
	end

	// State code output
	always_ff @(posedge core_clk) begin
		devState_r <= rst ? 3'h0 : st_r;
	end

	//======================================================================
	// Checks on the admission table, resume and OTP engine
	a_resume_busy: assert property (@(posedge core_clk) disable iff (rst)
		frameEnd && cls == CL_RESUME && admit |=> wip_r)
		else $error("resume did not set busy");
	a_resume_ready: assert property (@(posedge core_clk) disable iff (rst)
		frameEnd && cls == CL_RESUME && admit |=>
		!flagStat_r[FS_READY])
		else $error("resume did not clear ready flag");
	a_standby_susp: assert property (@(posedge core_clk) disable iff (rst)
		frameEnd && st_r == ST_STANDBY && cls == CL_SUSP &&
		bitCnt_r >= 10'h008 |=> cmdRejected_r)
		else $error("suspend accepted in standby");
	a_busy_refuse: assert property (@(posedge core_clk) disable iff (rst)
		frameEnd && st_r == ST_BUSY && bitCnt_r >= 10'h008 &&
		cls != CL_STAT && cls != CL_SUSP |=> cmdRejected_r)
		else $error("command accepted while busy");
	a_otp_start: assert property (@(posedge core_clk) disable iff (rst)
		goOtp |=> !wel_r && wip_r)
		else $error("OTP program start did not set busy and clear latch");
	a_lock_sticky: assert property (@(posedge core_clk) disable iff (rst)
		otpLocked_r |=> otpLocked_r)
		else $error("OTP lock returned to open");
	a_lock_hit: assert property (@(posedge core_clk) disable iff (rst)
		otpLockHit |=> flagStat_r[FS_PROT] &&
		flagStat_r[FS_PGFAIL] && wel_r)
		else $error("locked OTP program flags wrong");
	// Main scenarios reached
	c_nested: cover property (@(posedge core_clk) st_r == ST_NEST_SUSP);
	c_otp_run: cover property (@(posedge core_clk) goOtp);
	c_lock_hit: cover property (@(posedge core_clk) otpLockHit);
endmodule

// ===== dv/spi_host_model.sv
//======================================
// Serial host: mode 0, clock idle low
module spi_host_model (
	// Link pins
	output logic selectN,
	output logic serialClk,
	output logic serialIn,
	// Return data
	input wire logic serialOut,
	input wire logic serialOutEn
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int HALF = 200;
	// Idle levels, clock stands still between frames
	initial begin
		selectN = 1'b1;
		serialClk = 1'b0;
		serialIn = 1'b0;
	end
	// One frame: bytes out MSB first, then nRd bytes read back
	task automatic xfer(input logic [7:0] tx[$], input int nRd,
		output logic [7:0] rx[$]);
		logic [7:0] b;
		rx = {};
		selectN = 1'b0;
		#HALF;
		foreach (tx[i]) begin
			for (int k = 7; k >= 0; k--) begin
				serialIn = tx[i][k];
				#HALF;
				serialClk = 1'b1;
				#HALF;
				serialClk = 1'b0;
			end
		end
		for (int n = 0; n < nRd; n++) begin
			for (int k = 7; k >= 0; k--) begin
				serialIn = ~serialIn;
				#HALF;
				serialClk = 1'b1;
				b[k] = serialOutEn ? serialOut : 1'bx;
				#HALF;
				serialClk = 1'b0;
			end
			rx.push_back(b);
		end
		#HALF;
		// Select rises only after a whole byte
		selectN = 1'b1;
		serialIn = ~serialIn;
	endtask
endmodule

// ===== dv/flash_suspend_resume_otp_ctrl_tb.sv
//======================================
// Bench top
module flash_suspend_resume_otp_ctrl_tb;
	import flash_ctrl_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk, rst, selectN, serialClk, serialIn, sOut, sOutEn;
	logic opDone, opFail, suspSse, suspSe, suspPg, busyStart;
	logic [15:0] suspSector;
	logic [23:0] suspPage;
	logic [2:0] devState;
	logic wel, wip, locked, acc, rej, undef, recheck;
	logic [7:0] flags, code;
	logic [7:0] rxQ[$];
	int failCount = 0;
	int nChecks = 0;
	int cyc = 0;
	flash_suspend_resume_otp_ctrl #(.POTP_CYCLES(20)) dut_u (
		.core_clk(core_clk), .rst(rst), .selectN(selectN),
		.serialClk(serialClk), .serial_in_line(serialIn),
		.serial_out_line_r(sOut), .serialOutEn_r(sOutEn),
		.arrayOpDone(opDone), .arrayOpFail(opFail),
		.suspSector(suspSector), .suspPage(suspPage),
		.suspEraseSse(suspSse), .suspEraseSe(suspSe),
		.suspProgram(suspPg), .busyStart(busyStart),
		.devState_r(devState), .wel_r(wel), .wip_r(wip),
		.flagStat_r(flags), .otpLocked_r(locked), .cmdCode_r(code),
		.cmdAccepted_r(acc), .cmdRejected_r(rej),
		.dataUndefined_r(undef), .lockRecheck_r(recheck));
	spi_host_model host_u (.selectN(selectN), .serialClk(serialClk),
		.serialIn(serialIn), .serialOut(sOut), .serialOutEn(sOutEn));
	// Clock, 50 ns period
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	// Hang guard
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 30000) begin
			failCount++;
			reportAndStop();
		end
	end
	//======================================
	// Tasks
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		nChecks++;
		if (got !== exp) begin
			failCount++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// e: 1 accept expected, 0 reject expected, 2 not judged
	task automatic frame(input logic [7:0] tx[$], input int nRd,
		input int e);
		logic [1:0] res;
		res = 2'b00;
		host_u.xfer(tx, nRd, rxQ);
		for (int i = 0; i < 12; i++) begin
			@(posedge core_clk);
			#1;
			if (acc === 1'b1 || rej === 1'b1)
				res = {acc, rej};
		end
		if (e != 2)
			chk({6'h00, res}, (e == 1) ? 8'h02 : 8'h01);
	endtask
	task automatic pulse(ref logic s);
		@(posedge core_clk);
		#1;
		s = 1'b1;
		@(posedge core_clk);
		#1;
		s = 1'b0;
		repeat (2) @(posedge core_clk);
		#1;
	endtask
	task automatic waitIdle();
		for (int i = 0; i < 200 && wip !== 1'b0; i++) begin
			@(posedge core_clk);
			#1;
		end
	endtask
	task automatic reportAndStop();
		$display("checks=%0d mismatches=%0d", nChecks, failCount);
		if (failCount == 0 && nChecks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	//======================================
	// Main sequence
	initial begin
		{rst, opDone, opFail, suspSse, suspSe, suspPg, busyStart} = 7'h7F;
		{opDone, opFail, suspSse, suspSe, suspPg, busyStart} = 6'h00;
		suspSector = 16'h0005;
		suspPage = 24'h060000;
		repeat (6) @(posedge core_clk);
		#1;
		rst = 1'b0;
		repeat (4) @(posedge core_clk);
		#1;
		chk(flags, 8'h80);
		chk({5'h00, devState}, 8'h00);
		frame('{CMD_RESUME}, 0, 0);
		chk({6'h00, wel, wip}, 8'h00);
		frame('{CMD_OTPPG, 8'h00, 8'h00, 8'h00, 8'h11}, 0, 2);
		chk(flags, 8'h80);
		chk({6'h00, wel, wip}, 8'h00);
		frame('{CMD_WREN}, 0, 1);
		chk({7'h00, wel}, 8'h01);
		frame('{CMD_WRDI}, 0, 1);
		chk({7'h00, wel}, 8'h00);
		frame('{CMD_WREN}, 0, 1);
		frame('{CMD_OTPPG, 8'h00, 8'h00, 8'h00, 8'hA5, 8'h3C}, 0, 2);
		chk({flags[7], 5'h00, wel, wip}, 8'h01);
		waitIdle();
		chk(flags, 8'h80);
		chk({6'h00, wel, wip}, 8'h00);
		frame('{CMD_OTPRD, 8'h00, 8'h00, 8'h00, 8'h00}, 2, 2);
		chk(rxQ[0], 8'hA5);
		chk(rxQ[1], 8'h3C);
		frame('{CMD_WREN}, 0, 1);
		frame('{CMD_OTPPG, 8'h00, 8'h00, 8'h40, 8'h00}, 0, 2);
		waitIdle();
		chk({7'h00, locked}, 8'h01);
		frame('{CMD_OTPRD, 8'h00, 8'h00, 8'h3F, 8'h00}, 3, 2);
		chk(rxQ[0], 8'hFF);
		chk(rxQ[1], 8'h00);
		chk(rxQ[2], 8'h00);
		frame('{CMD_WREN}, 0, 1);
		frame('{CMD_OTPPG, 8'h00, 8'h00, 8'h01, 8'h55}, 0, 2);
		chk({6'h00, wel, wip}, 8'h02);
		chk(flags, 8'h92);
		frame('{CMD_CLFSR}, 0, 1);
		chk(flags, 8'h80);
		frame('{CMD_OTPRD, 8'h00, 8'h00, 8'h01, 8'h00}, 1, 2);
		chk(rxQ[0], 8'h3C);
		// Erase running, then suspended
		pulse(busyStart);
		chk({5'h00, devState}, 8'h01);
		frame('{CMD_WREN}, 0, 0);
		frame('{CMD_RDFSR}, 1, 1);
		frame('{CMD_WRSR, 8'h00}, 0, 0);
		pulse(suspSe);
		chk({5'h00, devState}, 8'h03);
		frame('{CMD_WRSR, 8'h00}, 0, 0);
		frame('{CMD_SE, 8'h07, 8'h00, 8'h00}, 0, 0);
		frame('{CMD_WREN}, 0, 1);
		frame('{CMD_PP, 8'h05, 8'h00, 8'h00, 8'h12}, 0, 0);
		frame('{CMD_PP, 8'h06, 8'h00, 8'h00, 8'h12}, 0, 1);
		frame('{CMD_READ, 8'h05, 8'h00, 8'h00}, 1, 1);
		// Program inside the erase suspend, then suspended too
		pulse(busyStart);
		pulse(suspPg);
		chk({5'h00, devState}, 8'h05);
		frame('{CMD_WRVCR, 8'hFB}, 0, 1);
		frame('{CMD_WREVCR, 8'hDF}, 0, 1);
		frame('{CMD_READ, 8'h06, 8'h01, 8'h00}, 1, 1);
		frame('{CMD_PP, 8'h07, 8'h00, 8'h00, 8'h12}, 0, 0);
		frame('{CMD_RESUME}, 0, 1);
		chk({devState, flags[7], 3'h0, wip}, 8'h21);
		pulse(opDone);
		chk({5'h00, devState}, 8'h03);
		frame('{CMD_RESUME}, 0, 1);
		chk({devState, recheck, 3'h0, wip}, 8'h21);
		pulse(opDone);
		chk({5'h00, devState}, 8'h00);
		frame('{CMD_SUSP}, 0, 0);
		reportAndStop();
	end
endmodule
